/* File: verilog/vgmc_pkg.sv */
// constants, types and register layout of the video misc control bank
// Summary of operation
// - re-encoder compatibility bit defaults off
// - gain value updates per line when 0
// - interval bit 1 updates gain per field
// - 3-bit analog test select, reserved codes ground
// - two bits pick ADC sample phase delay
// - crystal output pin driven only when 1
// - 9-bit start line raises gate, sets field_id to the current field
// - 50 Hz: 312/0/310 map to 1,2,312 lines
// - 60 Hz: 262/0/260 map to 4,5,265 lines
// - 9-bit stop line drops the gate
// - stop uses same line mapping as start
// - alternative position: gate earlier in field two
// - search latency in fields, 000 reserved
// - line clock outputs enabled when bit 0
// - raw gain: 0 off, 128 nominal
// - raw offset is offset binary around 128
// - status pin carries gate when selected
`default_nettype none
package vgmc_pkg;
    localparam logic [7:0] SUB_ANALOG = 8'h14;
    localparam logic [7:0] SUB_START_LO = 8'h15;
    localparam logic [7:0] SUB_STOP_LO = 8'h16;
    localparam logic [7:0] SUB_MISC = 8'h17;
    localparam logic [7:0] SUB_GAIN = 8'h18;
    localparam logic [7:0] SUB_OFFSET = 8'h19;
    localparam int NUM_REGS = 6;
    localparam logic [7:0] RST_ANALOG = 8'h00;
    localparam logic [7:0] RST_START_LO = 8'h00;
    localparam logic [7:0] RST_STOP_LO = 8'h00;
    localparam logic [7:0] RST_MISC = 8'h18;
    localparam logic [7:0] RST_GAIN = 8'h80;
    localparam logic [7:0] RST_OFFSET = 8'h80;
    // 14h fields
    localparam int B_COMPAT = 7;
    localparam int B_UPDATE = 6;
    localparam int B_ATS_HI = 5;
    localparam int B_ATS_LO = 4;
    localparam int B_XTAL = 3;
    localparam int B_AUTO = 2;
    localparam int B_PHASE_HI = 1;
    localparam int B_PHASE_LO = 0;
    // 17h fields
    localparam int B_LCK = 7;
    localparam int B_LCK2 = 6;
    localparam int B_LAT_HI = 5;
    localparam int B_LAT_LO = 3;
    localparam int B_ALT = 2;
    localparam int B_STOP8 = 1;
    localparam int B_START8 = 0;
    localparam logic [2:0] ATS_GROUND = 3'h0;
    localparam logic [2:0] ATS_RESV_A = 3'h5;
    localparam logic [2:0] ATS_RESV_B = 3'h6;
    localparam logic [2:0] LAT_RESERVED = 3'h0;
    localparam logic [2:0] LAT_RECOMMENDED = 3'h3;
    localparam logic [3:0] RT_SEL_GATE = 4'hd;
    // frame line mapping, 50 and 60 Hz
    localparam logic [11:0] FRAME_50 = 12'h271;
    localparam logic [11:0] FMOD_50 = 12'h139;
    localparam logic [11:0] BASE1_50 = 12'h002;
    localparam logic [11:0] BASE2_50 = 12'h13b;
    localparam logic [11:0] FRAME_60 = 12'h20d;
    localparam logic [11:0] FMOD_60 = 12'h107;
    localparam logic [11:0] BASE1_60 = 12'h005;
    localparam logic [11:0] BASE2_60 = 12'h10c;
    localparam int RAW_SHIFT = 7;
    localparam logic [10:0] RAW_ZERO = 11'h080;
    localparam logic [10:0] RAW_MAX = 11'h0ff;
    localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h21; // arbitrary value
    typedef struct packed {
        logic [9:0] line;
        logic field2;
        logic std60;
    } vgmc_line_pos_t;
    typedef struct packed {
        logic [8:0] start;
        logic [8:0] stop;
        logic alt;
    } vgmc_gate_cfg_t;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_ADDR_ACK = 4'h2,
        ST_SUB = 4'h3,
        ST_SUB_ACK = 4'h4,
        ST_WR = 4'h5,
        ST_WR_ACK = 4'h6,
        ST_RD = 4'h7,
        ST_RD_ACK = 4'h8
    } vgmc_st_t;
endpackage
`default_nettype wire

/* File: verilog/vgmc_line_map.sv */
// frame line to programming value conversion
`timescale 1ns/100ps
`default_nettype none
module vgmc_line_map
(
    input wire vgmc_pkg::vgmc_line_pos_t pos_in,
    output logic [8:0] value_out
);
    import vgmc_pkg::*;
    logic [11:0] base;
    logic [11:0] frame;
    logic [11:0] fmod;
    logic [11:0] d;
    always_comb
    begin
        frame = pos_in.std60 ? FRAME_60 : FRAME_50;
        fmod = pos_in.std60 ? FMOD_60 : FMOD_50;
        if (pos_in.std60)
            base = pos_in.field2 ? BASE2_60 : BASE1_60;
        else
            base = pos_in.field2 ? BASE2_50 : BASE1_50;
        d = {2'b00, pos_in.line} - base;
        // second field wraps past the frame's last line
        if (pos_in.field2 && ({2'b00, pos_in.line} < (frame >> 1)))
            d = d + frame;
        if (d[11])
            d = d + fmod;
        value_out = d[8:0];
    end
endmodule
`default_nettype wire

/* File: verilog/vgmc_raw_path.sv */
// raw data gain and offset stage, registered output
`timescale 1ns/100ps
`default_nettype none
module vgmc_raw_path
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic [7:0] raw_in,
    input wire logic [7:0] gain_in,
    input wire logic [7:0] offset_in,
    output logic [7:0] raw_out
);
    import vgmc_pkg::*;
    logic [15:0] prod;
    logic [10:0] sum;
    logic [7:0] raw_nxt;
    logic [7:0] raw_r;
    always_comb
    begin
        prod = {8'h00, raw_in} * {8'h00, gain_in};
        sum = {2'b00, prod[RAW_SHIFT +: 9]} + {3'b000, offset_in} - RAW_ZERO;
        if (sum[10])
            raw_nxt = 8'h00;
        else if (sum > RAW_MAX)
            raw_nxt = 8'hff;
        else
            raw_nxt = sum[7:0];
    end
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            raw_r <= 8'h00;
        else
            raw_r <= raw_nxt;
    end
    assign raw_out = raw_r;
    property p_raw_off;
        @(posedge clk_in) disable iff (!rst_b_in)
        (gain_in == 8'h00 && offset_in == 8'h80) |=> raw_out == 8'h00;
    endproperty
    a_raw_off: assert property (p_raw_off) else $error("raw gain zero not off");
    property p_raw_ofs;
        @(posedge clk_in) disable iff (!rst_b_in)
        (gain_in == 8'h00 && offset_in == 8'hff) |=> raw_out == 8'h7f;
    endproperty
    a_raw_ofs: assert property (p_raw_ofs) else $error("raw offset wrong");
endmodule
`default_nettype wire

/* File: verilog/vgmc_top.sv */
// misc control bank: serial register slave, gate, agc and pin controls
`timescale 1ns/100ps
`default_nettype none
module vgmc_top
#(
    parameter logic [6:0] DEV_ADDR = vgmc_pkg::DEV_ADDR_DEFAULT
)
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire vgmc_pkg::vgmc_line_pos_t pos_in,
    input wire logic line_strobe_in,
    input wire logic field_strobe_in,
    input wire logic [7:0] agc_value_in,
    input wire logic analog_sel_hi_in,
    input wire logic [3:0] rt_status_sel_in,
    input wire logic [7:0] raw_data_in,
    output logic [7:0] agc_value_out,
    output logic [2:0] analog_test_select_out,
    output logic [1:0] adc_phase_delay_out,
    output logic crystal_out_enable_out,
    output logic reencoder_compat_out,
    output logic auto_std_detect_ctrl_out,
    output logic vertical_gate_out,
    output logic field_id_out,
    output logic realtime_ctrl_out,
    output logic line_clock_out_enable_out,
    output logic half_line_clock_out_enable_out,
    output logic [2:0] std_search_latency_out,
    output logic [7:0] raw_data_out
);
    import vgmc_pkg::*;

    // pin synchronisers, third stage only for edge detection
    logic scl_s1_r, scl_s2_r, scl_d_r;
    logic sda_s1_r, sda_s2_r, sda_d_r;
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            scl_s1_r <= 1'b1;
            scl_s2_r <= 1'b1;
            scl_d_r <= 1'b1;
            sda_s1_r <= 1'b1;
            sda_s2_r <= 1'b1;
            sda_d_r <= 1'b1;
        end
        else
        begin
            scl_s1_r <= scl_in;
            scl_s2_r <= scl_s1_r;
            scl_d_r <= scl_s2_r;
            sda_s1_r <= sda_in;
            sda_s2_r <= sda_s1_r;
            sda_d_r <= sda_s2_r;
        end
    end
    logic scl_rise, scl_fall, bus_start, bus_stop;
    assign scl_rise = scl_s2_r & ~scl_d_r;
    assign scl_fall = ~scl_s2_r & scl_d_r;
    assign bus_start = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
    assign bus_stop = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;

    // serial slave and register bank
    vgmc_st_t st_r, st_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [7:0] shift_r, shift_nxt;
    logic [7:0] sub_r, sub_nxt;
    logic rw_r, rw_nxt;
    logic oe_r, oe_nxt;
    logic [7:0] bank_r [NUM_REGS];
    logic [7:0] bank_nxt [NUM_REGS];
    logic [7:0] rd_byte;
    logic [7:0] idx;
    always_comb
    begin
        idx = sub_r - SUB_ANALOG;
        rd_byte = 8'h00;
        for (int i = 0; i < NUM_REGS; i++)
        begin
            if (idx == 8'(i))
                rd_byte = bank_r[i];
        end
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        shift_nxt = shift_r;
        sub_nxt = sub_r;
        rw_nxt = rw_r;
        oe_nxt = oe_r;
        for (int i = 0; i < NUM_REGS; i++)
            bank_nxt[i] = bank_r[i];
        if (bus_stop)
        begin
            st_nxt = ST_IDLE;
            oe_nxt = 1'b0;
        end
        else if (bus_start)
        begin
            st_nxt = ST_ADDR;
            cnt_nxt = 4'h0;
            oe_nxt = 1'b0;
        end
        else
        begin
            unique case (st_r)
                ST_IDLE:
                begin
                    oe_nxt = 1'b0;
                end
                ST_ADDR, ST_SUB, ST_WR:
                begin
                    if (scl_rise)
                    begin
                        shift_nxt = {shift_r[6:0], sda_s2_r};
                        cnt_nxt = cnt_r + 4'h1;
                    end
                    else if (scl_fall && cnt_r == 4'h8)
                    begin
                        cnt_nxt = 4'h0;
                        oe_nxt = 1'b1;
                        if (st_r == ST_ADDR)
                        begin
                            rw_nxt = shift_r[0];
                            st_nxt = ST_ADDR_ACK;
                            if (shift_r[7:1] != DEV_ADDR)
                            begin
                                oe_nxt = 1'b0;
                                st_nxt = ST_IDLE;
                            end
                        end
                        else if (st_r == ST_SUB)
                        begin
                            sub_nxt = shift_r;
                            st_nxt = ST_SUB_ACK;
                        end
                        else
                        begin
                            // writes outside the bank are acknowledged, dropped
                            for (int i = 0; i < NUM_REGS; i++)
                            begin
                                if (idx == 8'(i))
                                    bank_nxt[i] = shift_r;
                            end
                            sub_nxt = sub_r + 8'h01;
                            st_nxt = ST_WR_ACK;
                        end
                    end
                end
                ST_ADDR_ACK:
                begin
                    if (scl_fall)
                    begin
                        cnt_nxt = 4'h0;
                        if (rw_r)
                        begin
                            shift_nxt = rd_byte;
                            oe_nxt = ~rd_byte[7];
                            st_nxt = ST_RD;
                        end
                        else
                        begin
                            oe_nxt = 1'b0;
                            st_nxt = ST_SUB;
                        end
                    end
                end
                ST_SUB_ACK, ST_WR_ACK:
                begin
                    if (scl_fall)
                    begin
                        oe_nxt = 1'b0;
                        cnt_nxt = 4'h0;
                        st_nxt = ST_WR;
                    end
                end
                ST_RD:
                begin
                    if (scl_fall)
                    begin
                        if (cnt_r == 4'h7)
                        begin
                            oe_nxt = 1'b0;
                            cnt_nxt = 4'h0;
                            sub_nxt = sub_r + 8'h01;
                            st_nxt = ST_RD_ACK;
                        end
                        else
                        begin
                            cnt_nxt = cnt_r + 4'h1;
                            shift_nxt = {shift_r[6:0], 1'b0};
                            oe_nxt = ~shift_r[6];
                        end
                    end
                end
                ST_RD_ACK:
                begin
                    // a not-acknowledge from the host ends the read
                    if (scl_rise && sda_s2_r)
                        st_nxt = ST_IDLE;
                    else if (scl_fall)
                    begin
                        shift_nxt = rd_byte;
                        oe_nxt = ~rd_byte[7];
                        st_nxt = ST_RD;
                    end
                end
                default:
                begin
                    st_nxt = ST_IDLE;
                    oe_nxt = 1'b0;
                end
            endcase
        end
    end
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            st_r <= ST_IDLE;
            cnt_r <= 4'h0;
            shift_r <= 8'h00;
            sub_r <= 8'h00;
            rw_r <= 1'b0;
            oe_r <= 1'b0;
            bank_r[0] <= RST_ANALOG;
            bank_r[1] <= RST_START_LO;
            bank_r[2] <= RST_STOP_LO;
            bank_r[3] <= RST_MISC;
            bank_r[4] <= RST_GAIN;
            bank_r[5] <= RST_OFFSET;
        end
        else
        begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            shift_r <= shift_nxt;
            sub_r <= sub_nxt;
            rw_r <= rw_nxt;
            oe_r <= oe_nxt;
            for (int i = 0; i < NUM_REGS; i++)
                bank_r[i] <= bank_nxt[i];
        end
    end
    // open drain: the line is only ever pulled low
    assign sda_out = 1'b0;
    assign sda_oe_out = oe_r;

    // gate, field id and gain update
    vgmc_gate_cfg_t cfg;
    logic [8:0] cur_val;
    logic [8:0] eff_val;
    logic [2:0] ats;
    logic [2:0] lat;
    assign cfg.start = {bank_r[3][B_START8], bank_r[1]};
    assign cfg.stop = {bank_r[3][B_STOP8], bank_r[2]};
    assign cfg.alt = bank_r[3][B_ALT];
    vgmc_line_map u_map
    (
        .pos_in(pos_in),
        .value_out(cur_val)
    );
    logic gate_r, gate_nxt, fld_r, fld_nxt, rt_r, rt_nxt;
    logic [7:0] agc_r, agc_nxt;
    logic [2:0] ats_r, ats_nxt, lat_r, lat_nxt;
    logic lck_r, lck_nxt, lck2_r, lck2_nxt;
    always_comb
    begin
        // one line earlier in field two: fire when next line matches
        eff_val = (cfg.alt && pos_in.field2) ? cur_val + 9'h001 : cur_val;
        gate_nxt = gate_r;
        fld_nxt = fld_r;
        if (line_strobe_in)
        begin
            if (eff_val == cfg.stop)
                gate_nxt = 1'b0;
            else if (eff_val == cfg.start)
                gate_nxt = 1'b1;
            if (cur_val == cfg.start)
                fld_nxt = pos_in.field2;
        end
        agc_nxt = agc_r;
        if (bank_r[0][B_UPDATE] ? field_strobe_in : line_strobe_in)
            agc_nxt = agc_value_in;
        rt_nxt = (rt_status_sel_in == RT_SEL_GATE) ? gate_nxt : 1'b0;
        ats = {analog_sel_hi_in, bank_r[0][B_ATS_HI:B_ATS_LO]};
        // reserved selections park the output on ground
        ats_nxt = (ats == ATS_RESV_A || ats == ATS_RESV_B) ? ATS_GROUND : ats;
        lat = bank_r[3][B_LAT_HI:B_LAT_LO];
        lat_nxt = (lat == LAT_RESERVED) ? LAT_RECOMMENDED : lat;
        lck_nxt = ~bank_nxt[3][B_LCK];
        lck2_nxt = ~bank_nxt[3][B_LCK2];
    end
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            gate_r <= 1'b0;
            fld_r <= 1'b0;
            agc_r <= 8'h00;
            rt_r <= 1'b0;
            ats_r <= ATS_GROUND;
            lat_r <= LAT_RECOMMENDED;
            lck_r <= 1'b1;
            lck2_r <= 1'b1;
        end
        else
        begin
            gate_r <= gate_nxt;
            fld_r <= fld_nxt;
            agc_r <= agc_nxt;
            rt_r <= rt_nxt;
            ats_r <= ats_nxt;
            lat_r <= lat_nxt;
            lck_r <= lck_nxt;
            lck2_r <= lck2_nxt;
        end
    end
    assign vertical_gate_out = gate_r;
    assign field_id_out = fld_r;
    assign agc_value_out = agc_r;
    assign realtime_ctrl_out = rt_r;
    assign analog_test_select_out = ats_r;
    assign std_search_latency_out = lat_r;
    assign line_clock_out_enable_out = lck_r;
    assign half_line_clock_out_enable_out = lck2_r;
    assign adc_phase_delay_out = bank_r[0][B_PHASE_HI:B_PHASE_LO];
    assign crystal_out_enable_out = bank_r[0][B_XTAL];
    assign reencoder_compat_out = bank_r[0][B_COMPAT];
    assign auto_std_detect_ctrl_out = bank_r[0][B_AUTO];
    vgmc_raw_path u_raw
    (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .raw_in(raw_data_in),
        .gain_in(bank_r[4]),
        .offset_in(bank_r[5]),
        .raw_out(raw_data_out)
    );

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_b_in);
    property p_compat_off;
        $rose(rst_b_in) |-> !reencoder_compat_out;
    endproperty
    a_compat_off: assert property (disable iff (1'b0) p_compat_off) else $error("compat not off");
    property p_agc_line;
        line_strobe_in && !bank_r[0][B_UPDATE] |=> agc_value_out == $past(agc_value_in);
    endproperty
    a_agc_line: assert property (p_agc_line) else $error("agc missed line update");
    property p_agc_field;
        bank_r[0][B_UPDATE] && !field_strobe_in |=> $stable(agc_value_out);
    endproperty
    a_agc_field: assert property (p_agc_field) else $error("agc updated off field");
    property p_ats_resv;
        (ats == ATS_RESV_A || ats == ATS_RESV_B) |=> analog_test_select_out == ATS_GROUND;
    endproperty
    a_ats_resv: assert property (p_ats_resv) else $error("reserved test select");
    property p_map50;
        !pos_in.std60 && !pos_in.field2 && pos_in.line == 10'h001 |-> cur_val == 9'h138;
    endproperty
    a_map50: assert property (p_map50) else $error("50 Hz line map wrong");
    property p_map60;
        pos_in.std60 && pos_in.field2 && pos_in.line == 10'h003 |-> cur_val == 9'h104;
    endproperty
    a_map60: assert property (p_map60) else $error("60 Hz line map wrong");
    property p_gate_stop;
        line_strobe_in && eff_val == cfg.stop |=> !vertical_gate_out;
    endproperty
    a_gate_stop: assert property (p_gate_stop) else $error("gate did not fall");
    property p_gate_start;
        line_strobe_in && eff_val == cfg.start && eff_val != cfg.stop |=> vertical_gate_out;
    endproperty
    a_gate_start: assert property (p_gate_start) else $error("gate did not rise");
    property p_gate_hold;
        !line_strobe_in |=> $stable(vertical_gate_out);
    endproperty
    a_gate_hold: assert property (p_gate_hold) else $error("gate moved mid line");
    property p_rt_gate;
        rt_status_sel_in == RT_SEL_GATE |=> realtime_ctrl_out == vertical_gate_out;
    endproperty
    a_rt_gate: assert property (p_rt_gate) else $error("status pin lost gate");
    property p_lat;
        std_search_latency_out != LAT_RESERVED;
    endproperty
    a_lat: assert property (p_lat) else $error("reserved latency out");
    property p_lck;
        ##1 line_clock_out_enable_out == !bank_r[3][B_LCK];
    endproperty
    a_lck: assert property (p_lck) else $error("line clock enable wrong");
    c_gate_rise: cover property ($rose(vertical_gate_out));
    c_write: cover property (st_r == ST_WR_ACK && sub_r == 8'h18);
    c_read: cover property (st_r == ST_RD && scl_fall && cnt_r == 4'h7);
    c_rt: cover property (realtime_ctrl_out);
endmodule
`default_nettype wire

/* File: bench/vgmc_host.sv */
// serial bus host model that programs and reads the control bank
`timescale 1ns/100ps
`default_nettype none
module vgmc_host
#(
    parameter logic [6:0] ADDR = vgmc_pkg::DEV_ADDR_DEFAULT
)
(
    input wire logic clk_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_pull_out
);
    logic nak_seen;
    initial
    begin
        scl_out = 1'b1;
        sda_pull_out = 1'b0;
        nak_seen = 1'b0;
    end
    task automatic tk(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    // data moves only mid-low so it never fakes a start or stop
    task automatic bit_io(input logic b, output logic r);
        sda_pull_out = !b;
        tk(5);
        scl_out = 1'b1;
        tk(5);
        r = sda_in;
        tk(5);
        scl_out = 1'b0;
        tk(5);
    endtask
    task automatic start();
        sda_pull_out = 1'b0;
        tk(5);
        scl_out = 1'b1;
        tk(10);
        sda_pull_out = 1'b1;
        tk(10);
        scl_out = 1'b0;
        tk(5);
    endtask
    task automatic stop();
        sda_pull_out = 1'b1;
        tk(5);
        scl_out = 1'b1;
        tk(10);
        sda_pull_out = 1'b0;
        tk(10);
    endtask
    // ninth bit always released: single-byte reads end with a nack
    task automatic xfer(input logic [7:0] d, input logic w,
                        output logic [7:0] r);
        logic a;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(d[i], r[i]);
        end
        bit_io(1'b1, a);
        if (w && a)
        begin
            nak_seen = 1'b1;
        end
    endtask
    task automatic write_reg(input logic [7:0] sub, input logic [7:0] d);
        logic [7:0] r;
        start();
        xfer({ADDR, 1'b0}, 1'b1, r);
        xfer(sub, 1'b1, r);
        xfer(d, 1'b1, r);
        stop();
    endtask
    task automatic read_reg(input logic [7:0] sub, output logic [7:0] d);
        start();
        xfer({ADDR, 1'b0}, 1'b1, d);
        xfer(sub, 1'b1, d);
        start();
        xfer({ADDR, 1'b1}, 1'b1, d);
        xfer(8'hff, 1'b0, d);
        stop();
    endtask
endmodule
`default_nettype wire

/* File: bench/tb_vgmc_top.sv */
// testbench for the video misc control bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin failures++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_vgmc_top;
    import vgmc_pkg::*;
    logic clk_in, rst_b_in, scl, pull, sda, lstb, fstb, sel_hi;
    logic sda_o, sda_oe, gate, fld, rt, lck_en, lck2_en, compat, xtal, autod;
    logic [7:0] agc_in, raw_in, agc_out, raw_out, rd;
    logic [3:0] rt_sel;
    logic [2:0] ats, lat;
    logic [1:0] phase;
    vgmc_line_pos_t pos;
    int failures = 0;
    int comparisons = 0;
    // open drain with pull-up
    assign sda = !(pull | (sda_oe & !sda_o));
    vgmc_host host (.clk_in(clk_in), .sda_in(sda), .scl_out(scl),
        .sda_pull_out(pull));
    vgmc_top dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .scl_in(scl),
        .sda_in(sda), .sda_out(sda_o), .sda_oe_out(sda_oe), .pos_in(pos),
        .line_strobe_in(lstb), .field_strobe_in(fstb), .agc_value_in(agc_in),
        .analog_sel_hi_in(sel_hi), .rt_status_sel_in(rt_sel),
        .raw_data_in(raw_in), .agc_value_out(agc_out),
        .analog_test_select_out(ats), .adc_phase_delay_out(phase),
        .crystal_out_enable_out(xtal), .reencoder_compat_out(compat),
        .auto_std_detect_ctrl_out(autod), .vertical_gate_out(gate),
        .field_id_out(fld), .realtime_ctrl_out(rt),
        .line_clock_out_enable_out(lck_en),
        .half_line_clock_out_enable_out(lck2_en),
        .std_search_latency_out(lat), .raw_data_out(raw_out));
    initial
    begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    task automatic print_verdict();
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic tk(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        tk(1);
        s = 1'b0;
        tk(1);
    endtask
    task automatic vline(input logic [9:0] ln, input logic f2, s60, eg, ef);
        pos = '{ln, f2, s60};
        pulse(lstb);
        `CHK(gate, eg)
        `CHK(rt, eg & (rt_sel == RT_SEL_GATE))
        `CHK(fld, ef)
    endtask
    task automatic t_reset();
        logic [7:0] ev [6] = '{RST_ANALOG, RST_START_LO, RST_STOP_LO,
            RST_MISC, RST_GAIN, RST_OFFSET};
        `CHK(compat, 1'b0)
        `CHK(lat, LAT_RECOMMENDED)
        for (int i = 0; i < 6; i++)
        begin
            host.read_reg(8'(SUB_ANALOG + i), rd);
            `CHK(rd, ev[i])
        end
        host.write_reg(8'h1a, 8'h5a);
        host.read_reg(8'h1a, rd);
        `CHK(rd, 8'h00)
    endtask
    task automatic t_analog();
        logic [2:0] c;
        logic [7:0] v;
        for (int i = 0; i < 8; i++)
        begin
            c = 3'(i);
            sel_hi = c[2];
            v = {c[0], 1'b0, c[1:0], c[0], c[1], c[1:0]};
            host.write_reg(SUB_ANALOG, v);
            tk(2);
            `CHK(ats, (c == 3'h5 || c == 3'h6) ? ATS_GROUND : c)
            `CHK(compat, c[0])
            `CHK(xtal, c[0])
            `CHK(phase, c[1:0])
            `CHK(autod, c[1])
            host.read_reg(SUB_ANALOG, rd);
            `CHK(rd, v)
        end
    endtask
    task automatic t_misc();
        logic [2:0] c;
        for (int i = 0; i < 8; i++)
        begin
            c = 3'(i);
            host.write_reg(SUB_MISC, {c[0], c[1], c, 3'h0});
            tk(2);
            `CHK(lat, (c == LAT_RESERVED) ? LAT_RECOMMENDED : c)
            `CHK(lck_en, !c[0])
            `CHK(lck2_en, !c[1])
        end
    endtask
    task automatic t_gate();
        host.write_reg(SUB_START_LO, 8'h38);
        host.write_reg(SUB_STOP_LO, 8'h36);
        host.write_reg(SUB_MISC, 8'h1b);
        vline(10'd314, 1'b1, 1'b0, 1'b1, 1'b1);
        vline(10'd500, 1'b1, 1'b0, 1'b1, 1'b1);
        vline(10'd625, 1'b1, 1'b0, 1'b0, 1'b1);
        vline(10'd1, 1'b0, 1'b0, 1'b1, 1'b0);
        vline(10'd312, 1'b0, 1'b0, 1'b0, 1'b0);
        host.write_reg(SUB_MISC, 8'h1f);
        vline(10'd313, 1'b1, 1'b0, 1'b1, 1'b0);
        vline(10'd624, 1'b1, 1'b0, 1'b0, 1'b0);
        vline(10'd1, 1'b0, 1'b0, 1'b1, 1'b0);
        host.write_reg(SUB_START_LO, 8'h06);
        host.write_reg(SUB_STOP_LO, 8'h04);
        host.write_reg(SUB_MISC, 8'h1b);
        vline(10'd265, 1'b0, 1'b1, 1'b0, 1'b0);
        vline(10'd267, 1'b1, 1'b1, 1'b1, 1'b1);
        vline(10'd3, 1'b1, 1'b1, 1'b0, 1'b1);
        rt_sel = 4'h0;
        vline(10'd4, 1'b0, 1'b1, 1'b1, 1'b0);
    endtask
    task automatic t_agc();
        host.write_reg(SUB_ANALOG, 8'h00);
        agc_in = 8'h5a;
        pulse(lstb);
        `CHK(agc_out, 8'h5a)
        host.write_reg(SUB_ANALOG, 8'h40);
        agc_in = 8'hc3;
        pulse(lstb);
        `CHK(agc_out, 8'h5a)
        pulse(fstb);
        `CHK(agc_out, 8'hc3)
    endtask
    task automatic t_raw();
        logic [7:0] tv [6][4] = '{'{8'h80, 8'h80, 8'h64, 8'h64},
            '{8'h00, 8'h80, 8'h64, 8'h00}, '{8'hff, 8'h80, 8'h40, 8'h7f},
            '{8'h80, 8'h00, 8'hc8, 8'h48}, '{8'h80, 8'hff, 8'h10, 8'h8f},
            '{8'h00, 8'hff, 8'h33, 8'h7f}};
        for (int i = 0; i < 6; i++)
        begin
            host.write_reg(SUB_GAIN, tv[i][0]);
            host.write_reg(SUB_OFFSET, tv[i][1]);
            raw_in = tv[i][2];
            tk(2);
            `CHK(raw_out, tv[i][3])
        end
    endtask
    initial
    begin
        rst_b_in = 1'b0;
        {lstb, fstb, sel_hi, agc_in, raw_in} = '0;
        pos = '0;
        rt_sel = RT_SEL_GATE;
        repeat (8) @(posedge clk_in);
        #1 rst_b_in = 1'b1;
        tk(3);
        t_reset();
        t_analog();
        t_misc();
        t_gate();
        t_agc();
        t_raw();
        `CHK(host.nak_seen, 1'b0)
        print_verdict();
    end
    // the full sequence needs about 35k cycles
    initial
    begin
        #3000000;
        failures++;
        print_verdict();
    end
endmodule
`default_nettype wire
